// ===== hdl/mlp_lock_protect.sv
// What this block does
// - In closed loop, electrical frequency above 3 kHz raises a lock.
// - At first start, measure back-EMF constant and derive lower and upper bounds.
// - In closed loop, running constant outside the bounds raises a lock.
// - In closed loop, computed back-EMF above applied amplitude for the confirm time raises a lock.
// - Open loop above handoff rate, no zero cross for 2 cycles: stuck lock.
// - Any lock stops drive, phases high impedance, restart after lock-off wait.
// - Open loop hands off to closed loop at the handoff frequency threshold.
// - Clamp amplitude to limit current times resistance plus speed times constant.
// - Current limit only in closed loop; no fault and no stop.
// - Limit selector: zero means none, n means n times 125 mA.
// - Phase current over the short-circuit limit puts all phases high impedance.
// - After short clears, rerun initialization and then restart.
// - Buffer the speed command and limit its rate of change.
// - Keep output amplitude above computed back-EMF.
// - Inductive surge at shutoff turns on the low-side switch.
// - Advance time equals selector times 20 us, up to 620 us.
`include "mlp_regs.svh"

module mlp_lock_protect #(
    parameter int unsigned LOCK_CONFIRM_CYC = `MLP_LOCK_CONFIRM_US * `MLP_CYC_PER_US,
    parameter int unsigned LOCK_OFF_CYC     = `MLP_LOCK_OFF_US * `MLP_CYC_PER_US
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    output logic             irq_out,
    input  wire logic        comm_tick_in,
    input  wire logic        zero_cross_in,
    input  wire logic [15:0] speed_in,
    input  wire logic [15:0] bemf_int_in,
    input  wire logic        bemf_int_valid_in,
    input  wire logic [15:0] rm_in,
    input  wire logic [15:0] cmd_in,
    input  wire logic        short_in,
    input  wire logic        surge_in,
    output logic      [15:0] amp_out,
    output logic             phase_hiz_out,
    output logic             low_side_switch_out,
    output logic             closed_loop_out,
    output logic             lock_out,
    output logic      [16:0] advance_time_out
);

    mlp_pkg::mlp_state_t  s;
    mlp_pkg::mlp_state_t  n;
    mlp_pkg::mlp_irq_t    ev;
    mlp_pkg::mlp_irq_t    clr;
    mlp_pkg::mlp_status_t stat;
    logic                 running;
    logic                 fast;
    logic                 stuck;
    logic                 spd_cond;
    logic                 lock_any;
    logic                 drive_nxt;
    logic [15:0]          bemf_calc;
    logic [15:0]          ulimit;
    logic [15:0]          floor_v;
    logic [15:0]          amp_v;
    logic [15:0]          diff;
    logic [31:0]          bemf_prod;
    logic [25:0]          ilim_prod;

    // Saturates a wide sum into the 16-bit amplitude range.
    function automatic logic [15:0] sat16(input logic [17:0] v);
        sat16 = (v > 18'h0ffff) ? 16'hffff : v[15:0];
    endfunction : sat16

    // Selector to milliamps; a zero selector yields zero and disables the limit.
    function automatic logic [9:0] ilim_ma(input logic [2:0] sel);
        ilim_ma = 10'(sel) * 10'(`MLP_ILIM_STEP_MA);
    endfunction : ilim_ma

    // Arithmetic shared by detectors and amplitude shaping.
    always_comb begin
        running   = (s.mode == mlp_pkg::MLP_OPEN) || (s.mode == mlp_pkg::MLP_CLOSED);
        bemf_prod = 32'(speed_in) * 32'(s.kt_ref);
        bemf_calc = s.kt_valid ? bemf_prod[`MLP_BEMF_SHIFT +: 16] : 16'h0000;
        ilim_prod = 26'(ilim_ma(s.cfg.current_limit_sel)) * 26'(rm_in);
        ulimit    = sat16(18'(ilim_prod >> `MLP_RM_SHIFT) + 18'(bemf_calc));
        floor_v   = sat16(18'(bemf_calc) + 18'h00001);
        fast      = (s.cfg.handoff_sel != 4'h0) &&
                    ((40'(s.period_cnt) * 40'(s.cfg.handoff_sel) * 40'(`MLP_HANDOFF_STEP_DHZ))
                     < `MLP_HANDOFF_NUM);
        stuck     = (3'(s.zc_miss) + 3'h1 >= 3'(`MLP_STUCK_CYCLES)) && !zero_cross_in;
        spd_cond  = (s.mode == mlp_pkg::MLP_CLOSED) && (bemf_calc > s.amp);
    end

    // Lock detectors, merged into one event below.
    always_comb begin
        ev = '0;
        ev.lock_freq  = (s.mode == mlp_pkg::MLP_CLOSED) && comm_tick_in &&
                        (s.period_cnt < 25'(`MLP_LOCK1_PERIOD_CYC));
        ev.lock_bemf  = (s.mode == mlp_pkg::MLP_CLOSED) && s.kt_valid && bemf_int_valid_in &&
                        ((bemf_int_in < s.kt_lo) || (bemf_int_in > s.kt_hi));
        ev.lock_speed = spd_cond && (s.conf_cnt >= 32'(LOCK_CONFIRM_CYC - 1));
        ev.lock_stuck = (s.mode == mlp_pkg::MLP_OPEN) && comm_tick_in && fast && stuck;
        ev.short_circuit = short_in && (s.mode != mlp_pkg::MLP_SHORT);
        lock_any = ev.lock_freq | ev.lock_bemf | ev.lock_speed | ev.lock_stuck;
    end

    // Next-state logic: bus, measurement, sequencer and drive shaping.
    always_comb begin
        n       = s;
        n.rdata = 32'h0000_0000;
        clr     = '0;
        stat    = '0;
        stat.kt_ref   = s.kt_ref;
        stat.kt_valid = s.kt_valid;
        stat.closed   = s.closed;
        stat.hiz      = s.hiz;
        stat.low_side = s.low_side;
        stat.mode     = s.mode;

        // Register writes; reserved control bits are forced to zero.
        if (wr_in) begin
            if (addr_in == `MLP_REG_CTRL) begin
                n.cfg = mlp_pkg::mlp_cfg_t'(wdata_in & `MLP_CTRL_WMASK);
            end else if (addr_in == `MLP_REG_IRQ_MASK) begin
                n.irq_mask = mlp_pkg::mlp_irq_t'(wdata_in[4:0]);
            end
        end

        // Register reads; unmapped offsets return zero.
        if (rd_in) begin
            if (addr_in == `MLP_REG_CTRL) begin
                n.rdata = s.cfg;
            end else if (addr_in == `MLP_REG_STATUS) begin
                n.rdata = stat;
            end else if (addr_in == `MLP_REG_IRQ_STAT) begin
                n.rdata = {27'h0000000, s.irq_stat};
                clr     = s.irq_stat;
            end else if (addr_in == `MLP_REG_IRQ_MASK) begin
                n.rdata = {27'h0000000, s.irq_mask};
            end
        end

        // Electrical period and missed zero crossings; both saturate.
        if (comm_tick_in) begin
            n.period_cnt = 25'h0000000;
        end else if (s.period_cnt != 25'h1ffffff) begin
            n.period_cnt = s.period_cnt + 25'h0000001;
        end
        if (zero_cross_in) begin
            n.zc_miss = 2'h0;
        end else if (comm_tick_in && s.zc_miss != 2'h3) begin
            n.zc_miss = s.zc_miss + 2'h1;
        end

        // Confirmation counter runs only while the abnormal-speed condition holds.
        if (!spd_cond) begin
            n.conf_cnt = 32'h0000_0000;
        end else if (s.conf_cnt != 32'hffff_ffff) begin
            n.conf_cnt = s.conf_cnt + 32'h0000_0001;
        end

        // Mode sequencer; a short outranks a lock, and a lock outranks a stop request.
        case (s.mode)
            mlp_pkg::MLP_IDLE: begin
                if (s.cfg.run) begin
                    n.mode = mlp_pkg::MLP_OPEN;
                end
            end
            mlp_pkg::MLP_OPEN: begin
                if (s.cfg.run && !s.kt_valid && bemf_int_valid_in) begin
                    n.kt_ref   = bemf_int_in;
                    n.kt_lo    = bemf_int_in - (bemf_int_in >> `MLP_KT_TOL_SHIFT);
                    n.kt_hi    = sat16(18'(bemf_int_in) + 18'(bemf_int_in >> `MLP_KT_TOL_SHIFT));
                    n.kt_valid = 1'b1;
                end
                if (lock_any) begin
                    n.mode = mlp_pkg::MLP_LOCKOFF;
                end else if (!s.cfg.run) begin
                    n.mode = mlp_pkg::MLP_IDLE;
                end else if (comm_tick_in && fast && zero_cross_in) begin
                    // Hand off only while the rotor still answers; a silent tick past the
                    // threshold counts as a miss, so the stuck detector gets its chance.
                    n.mode = mlp_pkg::MLP_CLOSED;
                end
            end
            mlp_pkg::MLP_CLOSED: begin
                if (lock_any) begin
                    n.mode = mlp_pkg::MLP_LOCKOFF;
                end else if (!s.cfg.run) begin
                    n.mode = mlp_pkg::MLP_IDLE;
                end
            end
            mlp_pkg::MLP_LOCKOFF: begin
                n.off_cnt = s.off_cnt + 32'h0000_0001;
                if (s.off_cnt >= 32'(LOCK_OFF_CYC - 1)) begin
                    n.mode = s.cfg.run ? mlp_pkg::MLP_OPEN : mlp_pkg::MLP_IDLE;
                end
            end
            mlp_pkg::MLP_SHORT: begin
                // Leaving a short forgets the measured constant so the start measures it again.
                if (!short_in) begin
                    n.mode     = mlp_pkg::MLP_IDLE;
                    n.kt_valid = 1'b0;
                    n.kt_ref   = 16'h0000;
                    n.kt_lo    = 16'h0000;
                    n.kt_hi    = 16'h0000;
                end
            end
            default: begin
                n.mode = mlp_pkg::MLP_IDLE;
            end
        endcase
        if (short_in) begin
            n.mode = mlp_pkg::MLP_SHORT;
        end
        if (n.mode != mlp_pkg::MLP_LOCKOFF) begin
            n.off_cnt = 32'h0000_0000;
        end
        if (n.mode == mlp_pkg::MLP_OPEN && s.mode != mlp_pkg::MLP_OPEN) begin
            n.zc_miss = 2'h0;
        end

        // Speed command slews toward its target by at most one step per tick.
        if (s.slew_div >= 8'(`MLP_SLEW_TICK_CYC - 1)) begin
            n.slew_div = 8'h00;
            if (cmd_in > s.cmd_eff) begin
                diff      = cmd_in - s.cmd_eff;
                n.cmd_eff = s.cmd_eff + ((diff > 16'(s.cfg.slew_step)) ? 16'(s.cfg.slew_step) : diff);
            end else begin
                diff      = s.cmd_eff - cmd_in;
                n.cmd_eff = s.cmd_eff - ((diff > 16'(s.cfg.slew_step)) ? 16'(s.cfg.slew_step) : diff);
            end
        end else begin
            diff       = 16'h0000;
            n.slew_div = s.slew_div + 8'h01;
        end

        // Amplitude: current limit in closed loop only, then the back-EMF floor wins.
        drive_nxt = (n.mode == mlp_pkg::MLP_OPEN) || (n.mode == mlp_pkg::MLP_CLOSED);
        amp_v     = s.cmd_eff;
        if (s.mode == mlp_pkg::MLP_CLOSED && s.cfg.current_limit_sel != 3'h0 && amp_v > ulimit) begin
            amp_v = ulimit;
        end
        if (s.kt_valid && amp_v < floor_v) begin
            amp_v = floor_v;
        end
        n.amp      = drive_nxt ? amp_v : 16'h0000;
        n.hiz      = !drive_nxt;
        n.low_side = !drive_nxt && surge_in;
        n.closed   = (n.mode == mlp_pkg::MLP_CLOSED);
        n.lock     = lock_any && running;
        n.adv      = 17'(s.cfg.advance_angle_sel) * 17'(`MLP_ADV_STEP_CYC);

        // Sticky events: a new event in the clearing read's cycle survives.
        n.irq_stat = (s.irq_stat & ~clr) | (running ? ev : (ev & 5'h10));
        n.irq      = |(n.irq_stat & n.irq_mask);
    end

    // The whole state is one register.
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s          <= '0;
            s.mode     <= mlp_pkg::MLP_IDLE;
            s.cfg      <= mlp_pkg::mlp_cfg_t'(`MLP_CTRL_RST);
            s.irq_stat <= `MLP_IRQ_RST;
            s.irq_mask <= `MLP_IRQ_RST;
            s.hiz      <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs come straight from the state register.
    assign rdata_out           = s.rdata;
    assign irq_out             = s.irq;
    assign amp_out             = s.amp;
    assign phase_hiz_out       = s.hiz;
    assign low_side_switch_out = s.low_side;
    assign closed_loop_out     = s.closed;
    assign lock_out            = s.lock;
    assign advance_time_out    = s.adv;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    a_freq_lock: assert property (
        (s.mode == mlp_pkg::MLP_CLOSED) && comm_tick_in && !short_in &&
        (s.period_cnt < 25'(`MLP_LOCK1_PERIOD_CYC)) |=> lock_out && phase_hiz_out)
        else $error("Frequency overflow did not lock.");
    a_kt_window: assert property (
        s.kt_valid |-> (s.kt_lo <= s.kt_ref) && (s.kt_ref <= s.kt_hi))
        else $error("Constant bounds do not bracket the reference.");
    a_kt_lock: assert property (
        (s.mode == mlp_pkg::MLP_CLOSED) && s.kt_valid && bemf_int_valid_in &&
        (bemf_int_in > s.kt_hi) |=> lock_out)
        else $error("Out-of-window constant did not lock.");
    a_speed_count: assert property (
        spd_cond && (s.conf_cnt < 32'(LOCK_CONFIRM_CYC)) |=> s.conf_cnt == $past(s.conf_cnt) + 32'h1)
        else $error("Confirm counter did not advance.");
    a_speed_reset: assert property (
        !spd_cond |=> s.conf_cnt == 32'h0)
        else $error("Confirm counter not cleared.");
    a_stuck_lock: assert property (
        (s.mode == mlp_pkg::MLP_OPEN) && comm_tick_in && fast && (s.zc_miss >= 2'h1) &&
        !zero_cross_in |=> lock_out ##1 phase_hiz_out)
        else $error("Open-loop stuck not detected.");
    a_lock_wait: assert property (
        (s.mode == mlp_pkg::MLP_LOCKOFF) && (n.mode != mlp_pkg::MLP_LOCKOFF) && !short_in
        |-> s.off_cnt == 32'(LOCK_OFF_CYC - 1))
        else $error("Restart before lock-off wait ended.");
    a_lock_hiz: assert property (
        lock_out |-> phase_hiz_out && !closed_loop_out)
        else $error("Drive still on after lock.");
    a_handoff: assert property (
        (s.mode == mlp_pkg::MLP_OPEN) && s.cfg.run && comm_tick_in && fast && !lock_any &&
        zero_cross_in && !short_in |=> closed_loop_out)
        else $error("Handoff to closed loop missed.");
    a_ilim_clamp: assert property (
        (s.mode == mlp_pkg::MLP_CLOSED) && (n.mode == mlp_pkg::MLP_CLOSED) &&
        (s.cfg.current_limit_sel != 3'h0) |=> (amp_out <= $past(ulimit)) || (amp_out == $past(floor_v)))
        else $error("Amplitude above the current limit.");
    a_short_hiz: assert property (
        short_in |=> phase_hiz_out && !closed_loop_out)
        else $error("Short did not stop the drive.");
    a_short_reinit: assert property (
        (s.mode == mlp_pkg::MLP_SHORT) && !short_in |=> !s.kt_valid && (s.kt_ref == 16'h0000) &&
        (s.mode == mlp_pkg::MLP_IDLE))
        else $error("Initialization not rerun after short.");
    a_slew_rate: assert property (
        (s.cmd_eff >= $past(s.cmd_eff) ? s.cmd_eff - $past(s.cmd_eff) : $past(s.cmd_eff) - s.cmd_eff)
        <= 16'($past(s.cfg.slew_step)))
        else $error("Speed command moved too fast.");
    a_bemf_floor: assert property (
        !phase_hiz_out && $past(s.kt_valid) |-> (amp_out > $past(bemf_calc)) || (amp_out == 16'hffff))
        else $error("Amplitude not above back-EMF.");
    a_low_side: assert property (
        low_side_switch_out |-> phase_hiz_out && $past(surge_in))
        else $error("Low-side switch on while driving.");
    a_adv_time: assert property (
        ##1 advance_time_out == 17'($past(s.cfg.advance_angle_sel)) * 17'(`MLP_ADV_STEP_CYC))
        else $error("Advance time mismatch.");

endmodule : mlp_lock_protect

// ===== hdl/mlp_pkg.sv
package mlp_pkg;

    // Operating modes of the drive sequencer.
    typedef enum logic [2:0] {
        MLP_IDLE,
        MLP_OPEN,
        MLP_CLOSED,
        MLP_LOCKOFF,
        MLP_SHORT
    } mlp_mode_t;

    // Control word as software writes it.
    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [7:0] slew_step;
        logic [2:0] rsvd_lo;
        logic [3:0] handoff_sel;
        logic [4:0] advance_angle_sel;
        logic [2:0] current_limit_sel;
        logic       run;
    } mlp_cfg_t;

    // Sticky event bits, shared by status and mask.
    typedef struct packed {
        logic short_circuit;
        logic lock_stuck;
        logic lock_speed;
        logic lock_bemf;
        logic lock_freq;
    } mlp_irq_t;

    // Read-only status word.
    typedef struct packed {
        logic [15:0] kt_ref;
        logic [8:0]  rsvd;
        logic        kt_valid;
        logic        closed;
        logic        hiz;
        logic        low_side;
        logic [2:0]  mode;
    } mlp_status_t;

    // Whole state of the block.
    typedef struct packed {
        mlp_mode_t   mode;
        mlp_cfg_t    cfg;
        mlp_irq_t    irq_stat;
        mlp_irq_t    irq_mask;
        logic        irq;
        logic [31:0] rdata;
        logic [24:0] period_cnt;
        logic [1:0]  zc_miss;
        logic [15:0] kt_ref;
        logic [15:0] kt_lo;
        logic [15:0] kt_hi;
        logic        kt_valid;
        logic [31:0] conf_cnt;
        logic [31:0] off_cnt;
        logic [7:0]  slew_div;
        logic [15:0] cmd_eff;
        logic [15:0] amp;
        logic        hiz;
        logic        low_side;
        logic        closed;
        logic        lock;
        logic [16:0] adv;
    } mlp_state_t;

endpackage : mlp_pkg

// ===== hdl/mlp_regs.svh
`ifndef MLP_REGS_SVH
`define MLP_REGS_SVH

// Clock rate and period.
`define MLP_CLK_HZ            200000000
`define MLP_CLK_PERIOD_NS     5
`define MLP_CYC_PER_US        (1000 / `MLP_CLK_PERIOD_NS)

// Frequency overflow: one electrical cycle shorter than this count trips.
`define MLP_LOCK1_FREQ_HZ     3000
`define MLP_LOCK1_PERIOD_CYC  (`MLP_CLK_HZ / `MLP_LOCK1_FREQ_HZ)

// Handoff threshold is the selector times 12.5 Hz, kept in tenths of a hertz.
`define MLP_HANDOFF_STEP_DHZ  125
`define MLP_HANDOFF_NUM       (40'd10 * 40'd`MLP_CLK_HZ)
`define MLP_STUCK_CYCLES      2

// Soft current limit and advance time steps.
`define MLP_ILIM_STEP_MA      125
`define MLP_RM_SHIFT          10
`define MLP_BEMF_SHIFT        16
`define MLP_ADV_STEP_NS       20000
`define MLP_ADV_STEP_CYC      (`MLP_ADV_STEP_NS / `MLP_CLK_PERIOD_NS)

// Speed command slew tick and acceptable constant window.
`define MLP_SLEW_TICK_NS      1000
`define MLP_SLEW_TICK_CYC     (`MLP_SLEW_TICK_NS / `MLP_CLK_PERIOD_NS)
`define MLP_KT_TOL_SHIFT      2

// Lock confirmation and lock-off wait times.
`define MLP_LOCK_CONFIRM_US   1000
`define MLP_LOCK_OFF_US       5000000

// Register map.
`define MLP_REG_CTRL          8'h00
`define MLP_REG_STATUS        8'h04
`define MLP_REG_IRQ_STAT      8'h08
`define MLP_REG_IRQ_MASK      8'h0c
`define MLP_CTRL_RST          32'h0001_0000
`define MLP_CTRL_WMASK        32'h00ff_1fff
`define MLP_IRQ_RST           5'h00

`endif

// ===== verif/mlp_motor_model.sv
// Behavioural three-phase motor as the block sees it: one commutation tick per
// electrical cycle and, while the rotor follows, a zero crossing with each tick.
module mlp_motor_model (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        spin_in,
    input  wire logic        zc_en_in,
    input  wire logic [15:0] period_in,
    output logic             comm_tick_out,
    output logic             zero_cross_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cnt_q;

    // A stalled rotor gives no ticks, so nothing arrives while spin_in is low.
    // With zc_en_in low the rotor is stuck and the crossings are missing.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q          <= 16'h0000;
            comm_tick_out  <= 1'b0;
            zero_cross_out <= 1'b0;
        end else begin
            comm_tick_out  <= 1'b0;
            zero_cross_out <= 1'b0;
            cnt_q          <= spin_in ? cnt_q + 16'h0001 : 16'h0000;
            if (spin_in && cnt_q >= period_in - 16'h0001) begin
                cnt_q          <= 16'h0000;
                comm_tick_out  <= 1'b1;
                zero_cross_out <= zc_en_in;
            end
        end
    end
endmodule : mlp_motor_model

// ===== verif/motor_lock_and_protection_control_test.sv
// Self-checking bench: bus reads queue their expected data, a monitor compares.
module motor_lock_and_protection_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_b, wr, rd, rd_q, bv, shrt, surge, spin, zc_en;
    logic        irq, hiz, low_sw, closed, lock, tick, zc;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, bad_count, comparisons, lock_cnt, base;
    logic [15:0] speed, bemf, rm, cmd, amp, a0;
    logic [16:0] adv;
    logic [31:0] exp_q[$];
    int          n, sel;

    mlp_lock_protect #(.LOCK_CONFIRM_CYC(20), .LOCK_OFF_CYC(50)) DUT (
        .clk_sys_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .comm_tick_in(tick), .zero_cross_in(zc),
        .speed_in(speed), .bemf_int_in(bemf), .bemf_int_valid_in(bv), .rm_in(rm), .cmd_in(cmd),
        .short_in(shrt), .surge_in(surge), .amp_out(amp), .phase_hiz_out(hiz),
        .low_side_switch_out(low_sw), .closed_loop_out(closed), .lock_out(lock), .advance_time_out(adv));

    mlp_motor_model motor (.clk_in(clk), .rst_b_in(rst_b), .spin_in(spin), .zc_en_in(zc_en),
        .period_in(16'h00c8), .comm_tick_out(tick), .zero_cross_out(zc));

    // Clock at 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    endtask : rd_chk

    // Bounded wait: 0 closed loop, 1 lock pulse, 2 drive resumed.
    task automatic wait_on(input int which, input int lim);
        int k;
        k = 0;
        while (!((which == 0 && closed === 1'b1) || (which == 1 && lock === 1'b1) ||
                 (which == 2 && hiz === 1'b0))) begin
            @(posedge clk);
            k++;
            if (k > lim) begin
                bad_count++;
                give_verdict();
            end
        end
    endtask : wait_on

    // Read data stand only in the cycle after the strobe, so compare exactly then.
    always @(posedge clk) begin
        rd_q <= rd;
        if (lock === 1'b1) lock_cnt++;
        if (rd_q === 1'b1) check(rdata, exp_q.pop_front());
    end

    initial begin
        {rst_b, wr, rd, rd_q, bv, shrt, surge, spin, zc_en} = '0;
        {addr, wdata, bad_count, comparisons, lock_cnt, speed, bemf, cmd} = '0;
        rm = 16'h0400;
        void'($urandom(39));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({31'h0, hiz}, 32'h1);
        rd_chk(8'h00, 32'h0001_0000);
        wr_reg(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h00, 32'h0001_0000);
        wr_reg(8'h0c, 32'h1f);
        // Advance time per selector, top value included.
        for (n = 0; n < 4; n++) begin
            sel = (n == 0) ? 31 : $urandom % 32;
            wr_reg(8'h00, 32'h0001_0000 | (sel << 4));
            repeat (2) @(posedge clk);
            check({15'h0, adv}, sel * 4000);
        end
        // Surge while the phases float turns the low-side switch on.
        surge <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, low_sw}, 32'h1);
        surge <= 1'b0;
        cmd   <= 16'hffff;
        base = 32'h0001_0201;
        wr_reg(8'h00, base);
        wait_on(2, 20);
        bemf <= 16'd1000;
        bv   <= 1'b1;
        @(posedge clk);
        bv   <= 1'b0;
        rd_chk(8'h04, 32'h03e8_0041);
        spin  <= 1'b1;
        zc_en <= 1'b1;
        wait_on(0, 1000);
        spin <= 1'b0;
        // Effective command creeps at one step per slew tick.
        a0 = amp;
        repeat (400) @(posedge clk);
        check({31'h0, (amp > a0) && (amp - a0 <= 16'd3)}, 32'h1);
        a0 = lock_cnt[15:0];
        for (n = 1; n < 8; n++) begin
            wr_reg(8'h00, 32'h00ff_0201 | (n << 1));
            repeat (1000) @(posedge clk);
            check({16'h0, amp}, n * 125);
        end
        wr_reg(8'h00, 32'h00ff_0201);
        repeat (200) @(posedge clk);
        check({31'h0, amp > 16'd875}, 32'h1);
        // Falling command with a fast rotor: amplitude stays just above back-EMF.
        speed <= 16'hffff;
        cmd   <= 16'h0000;
        wr_reg(8'h00, 32'h00ff_0203);
        repeat (12000) @(posedge clk);
        check({16'h0, amp}, 32'd1000);
        check({lock_cnt[15:0], 15'h0, closed}, {a0, 16'h1});
        speed <= 16'h0000;
        bemf  <= 16'd1300;
        bv    <= 1'b1;
        @(posedge clk);
        bv    <= 1'b0;
        wait_on(1, 5);
        check({30'h0, hiz, closed}, 32'h2);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h08, 32'h02);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wait_on(2, 100);
        rd_chk(8'h04, 32'h03e8_0041);
        spin <= 1'b1;
        wait_on(0, 1000);
        // Speed ramps faster than the amplitude follows, so computed back-EMF stays above it.
        n = 0;
        while (lock !== 1'b1 && n < 40) begin
            n++;
            speed <= 16'(n * 512);
            @(posedge clk);
        end
        check(n, 32'd21);
        speed <= 16'h0000;
        rd_chk(8'h08, 32'h04);
        wait_on(2, 100);
        wait_on(1, 1000);
        spin <= 1'b0;
        rd_chk(8'h08, 32'h01);
        wait_on(2, 100);
        shrt <= 1'b1;
        repeat (3) @(posedge clk);
        check({hiz, 15'h0, amp}, 32'h8000_0000);
        rd_chk(8'h08, 32'h10);
        shrt <= 1'b0;
        wait_on(2, 20);
        rd_chk(8'h04, 32'h0000_0001);
        // A rotor that stops answering in open loop must trip the stuck lock.
        zc_en <= 1'b0;
        spin  <= 1'b1;
        wait_on(1, 1000);
        check({30'h0, hiz, closed}, 32'h2);
        rd_chk(8'h08, 32'h08);
        repeat (4) @(posedge clk);
        give_verdict();
    end
endmodule : motor_lock_and_protection_control_test
